// ---- core_model.sv ----
// Behavioural processor core that takes normal and fast exceptions
`timescale 1ns/1ps
`default_nettype none
module core_model
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       normal_exc_request_n,
    input  wire logic       fast_exc_request_n,
    input  wire logic       irq_off,
    output var  logic [7:0] irq_taken,
    output var  logic [7:0] fiq_taken
);
    logic irq_q;
    logic fiq_q;
    // --------------------------------------------------------------
    // Count entries on each newly asserted fast line, and on a newly asserted normal line while irq_off is low
    // --------------------------------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_q <= 1'b1;
            fiq_q <= 1'b1;
            irq_taken <= 8'h00;
            fiq_taken <= 8'h00;
        end
        else
        begin
            irq_q <= normal_exc_request_n;
            fiq_q <= fast_exc_request_n;
            if (irq_q && !normal_exc_request_n && !irq_off)
                irq_taken <= irq_taken + 8'h01;
            if (fiq_q && !fast_exc_request_n)
                fiq_taken <= fiq_taken + 8'h01;
        end
    end
endmodule
`default_nettype wire

// ---- irq_ctl_checker.sv ----
// Port assertions for the nested interrupt control
`timescale 1ns/1ps
`default_nettype none
module irq_ctl_checker
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        ext_fast_request_pin_n,
    input wire logic        normal_exc_request_n,
    input wire logic        fast_exc_request_n
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable;
    // --------------------------------------------------------------
    // Bus and request line relations
    // --------------------------------------------------------------
    a_ready_high: assert property (psel |-> pready)
        else $error("pready low in a transfer");
    a_unmapped_err: assert property (acc && paddr > 8'h1c |-> pslverr)
        else $error("no error on unmapped address");
    a_mapped_ok: assert property (acc && paddr <= 8'h1c && !paddr[1:0]
        |-> !pslverr) else $error("error on mapped address");
    a_number_read: assert property (acc && !pwrite && paddr == 8'h14
        |=> normal_exc_request_n) else $error("normal line kept low");
    a_fast_clear: assert property (acc && pwrite && paddr == 8'h18
        && pwdata[0] |=> fast_exc_request_n) else $error("fast line kept");
    a_fast_cause: assert property ($fell(fast_exc_request_n)
        && !$past(psel) |-> !$past(ext_fast_request_pin_n, 3))
        else $error("fast line fell without a pin edge");
    a_fast_holds: assert property (!fast_exc_request_n && !psel
        |=> !fast_exc_request_n) else $error("fast line dropped");
    a_normal_holds: assert property (!normal_exc_request_n && !psel
        |=> !normal_exc_request_n) else $error("normal line dropped");
endmodule
bind nested_level_interrupt_control irq_ctl_checker chk_i
(
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .ext_fast_request_pin_n(ext_fast_request_pin_n),
    .normal_exc_request_n(normal_exc_request_n),
    .fast_exc_request_n(fast_exc_request_n)
);
`default_nettype wire

// ---- nested_irq_regs.vh ----
// Register offsets, field positions and reset values of the interrupt control
`ifndef NESTED_IRQ_REGS_VH
`define NESTED_IRQ_REGS_VH

// Register byte offsets
`define OFS_PENDING      8'h00
`define OFS_LEVEL_LO     8'h04
`define OFS_LEVEL_HI     8'h08
`define OFS_IN_SERVICE   8'h0c
`define OFS_REQ_LEVEL    8'h10
`define OFS_SRC_NUMBER   8'h14
`define OFS_FAST_CTRL    8'h18
`define OFS_SENSE_CTRL   8'h1c

// Source counts and field widths
`define NUM_EXT          8
`define NUM_SRC          16
`define LVL_W            3
`define SRC_W            4
`define LVL_FIELD_STRIDE 4

// Fast request control fields
`define FAST_PEND_BIT    0
`define FAST_MASK_BIT    1

// Reset values
`define RST_FAST_MASK    1'b0
`define RST_SENSE        8'h00
`define RST_LEVELS       48'h0000_0000_0000
`define RST_IN_SERVICE   8'h00

`endif

// ---- nested_level_interrupt_control.v ----
// Nested level interrupt controller with fast request and APB registers
`timescale 1ns/1ps
`default_nettype none
`include "nested_irq_regs.vh"

// Functional notes
// - Request above all in-service levels loads level, asserts request.
// - Source-number read sets in-service bit of held level, drops request.
// - Higher level during service updates level register, reasserts request.
// - Fast request asserts its line regardless of in-service levels.
// - Writing one to fast pending flag clears it and the fast line.
// - Writing one to a pending bit clears that pending flag.
// - Fast pin sampled each edge; high-to-low sets fast pending flag.
// - Falling-edge sensed pins set pending flag on high-to-low sample.
// - Low-level sensed pins set pending flag on every low sample.
// - Pin requests take two cycles more than internal ones to reach flags.
// - Request line holds until taken, covering instruction completion wait.
// - Request line holds through the processor's two dummy fetches.
// - Masked or not-above-service pending flags produce no processor request.
// - Level zero blocks a source; one to seven enable, seven highest.
// - Highest level wins, ties to lowest source number; both registered.
module nested_level_interrupt_control
#(
    // Register map and arbitration are laid out for the default counts
    parameter NUM_EXT = 8,
    parameter NUM_INT = 8
)
(
    input  wire                 pclk,
    input  wire                 presetn,
    input  wire                 psel,
    input  wire                 penable,
    input  wire                 pwrite,
    input  wire [7:0]           paddr,
    input  wire [31:0]          pwdata,
    output wire                 pready,
    output reg  [31:0]          prdata,
    output reg                  pslverr,
    input  wire [NUM_EXT-1:0]   ext_request_pins_n,
    input  wire                 ext_fast_request_pin_n,
    input  wire [NUM_INT-1:0]   int_requests,
    output reg                  normal_exc_request_n,
    output reg                  fast_exc_request_n
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    reg  [7:0]                  ext_sync1_r;
    reg  [7:0]                  ext_sync2_r;
    reg  [7:0]                  ext_prev_r;
    reg                         fast_sync1_r;
    reg                         fast_sync2_r;
    reg                         fast_prev_r;

    reg  [15:0]                 pending_flag_regs_r;
    reg  [15:0]                 pending_nxt;
    reg  [47:0]                 level_r;
    reg  [7:0]                  in_service_levels_r;
    reg  [7:0]                  in_service_nxt;
    reg  [2:0]                  request_level_reg_r;
    reg  [3:0]                  source_number_reg_r;
    reg                         fast_pending_flag_r;
    reg                         fast_mask_r;
    reg  [7:0]                  sense_r;
    reg                         fast_pend_nxt;
    reg                         fast_mask_nxt;
    reg                         normal_nxt;

    reg  [2:0]                  top_service;
    reg  [2:0]                  best_lvl;
    reg  [3:0]                  best_src;
    reg                         any_eligible;
    reg  [2:0]                  cand_lvl;
    reg  [31:0]                 rd_mux;
    reg                         rd_hit;
    integer                     i;

    wire                        setup_ph;
    wire                        access_ph;
    wire                        wr_en;
    wire                        src_read;
    wire                        src_addr_busy;
    wire [7:0]                  ext_fall;
    wire [7:0]                  ext_set;
    wire [15:0]                 src_set;
    wire                        fast_fall;

    wire                        wr_pending;
    wire                        wr_level_lo;
    wire                        wr_level_hi;
    wire                        wr_in_service;
    wire                        wr_fast;
    wire                        wr_sense;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function [2:0] lvl_of;
        input [47:0] levels;
        input [3:0]  src;
        begin
            lvl_of = levels[src*`LVL_W +: `LVL_W];
        end
    endfunction

    function [31:0] pack_levels;
        input [23:0] lv;
        integer k;
        begin
            pack_levels = 32'h0000_0000;
            for (k = 0; k < 8; k = k + 1)
            begin
                pack_levels[k*`LVL_FIELD_STRIDE +: `LVL_W] =
                    lv[k*`LVL_W +: `LVL_W];
            end
        end
    endfunction

    function [23:0] unpack_levels;
        input [31:0] w;
        integer k;
        begin
            unpack_levels = 24'h00_0000;
            for (k = 0; k < 8; k = k + 1)
            begin
                unpack_levels[k*`LVL_W +: `LVL_W] =
                    w[k*`LVL_FIELD_STRIDE +: `LVL_W];
            end
        end
    endfunction

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    assign pready        = 1'b1;
    assign setup_ph      = psel & ~penable;
    assign access_ph     = psel & penable;
    assign wr_en         = access_ph & pwrite & ~pslverr;
    assign src_read      = access_ph & ~pwrite & (paddr == `OFS_SRC_NUMBER);
    assign src_addr_busy = psel & ~pwrite & (paddr == `OFS_SRC_NUMBER);

    assign wr_pending    = wr_en & (paddr == `OFS_PENDING);
    assign wr_level_lo   = wr_en & (paddr == `OFS_LEVEL_LO);
    assign wr_level_hi   = wr_en & (paddr == `OFS_LEVEL_HI);
    assign wr_in_service = wr_en & (paddr == `OFS_IN_SERVICE);
    assign wr_fast       = wr_en & (paddr == `OFS_FAST_CTRL);
    assign wr_sense      = wr_en & (paddr == `OFS_SENSE_CTRL);

    // ------------------------------------------------------------
    // Pin sampling
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ext_sync1_r  <= 8'hff;
            ext_sync2_r  <= 8'hff;
            ext_prev_r   <= 8'hff;
            fast_sync1_r <= 1'b1;
            fast_sync2_r <= 1'b1;
            fast_prev_r  <= 1'b1;
        end
        else
        begin
            ext_sync1_r  <= ext_request_pins_n;
            ext_sync2_r  <= ext_sync1_r;
            ext_prev_r   <= ext_sync2_r;
            fast_sync1_r <= ext_fast_request_pin_n;
            fast_sync2_r <= fast_sync1_r;
            fast_prev_r  <= fast_sync2_r;
        end
    end

    assign ext_fall  = ext_prev_r & ~ext_sync2_r;
    assign ext_set   = (sense_r & ~ext_sync2_r)
                     | (~sense_r & ext_fall);
    assign fast_fall = fast_prev_r & ~fast_sync2_r;
    assign src_set   = {int_requests, ext_set};

    // ------------------------------------------------------------
    // Arbitration
    // ------------------------------------------------------------
    always @*
    begin
        top_service  = 3'd0;
        best_lvl     = 3'd0;
        best_src     = 4'd0;
        any_eligible = 1'b0;
        cand_lvl     = 3'd0;
        for (i = 1; i < 8; i = i + 1)
        begin
            if (in_service_levels_r[i])
                top_service = i[2:0];
        end
        // Lowest source number has the higher fixed priority
        for (i = `NUM_SRC - 1; i >= 0; i = i - 1)
        begin
            cand_lvl = lvl_of(level_r, i[3:0]);
            if (pending_flag_regs_r[i] && (cand_lvl > top_service)
                && (cand_lvl != 3'd0)
                && (cand_lvl >= best_lvl))
            begin
                any_eligible = 1'b1;
                best_lvl     = cand_lvl;
                best_src     = i[3:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Next-state of flags
    // ------------------------------------------------------------
    always @*
    begin
        pending_nxt = pending_flag_regs_r;
        if (wr_pending)
            pending_nxt = pending_nxt & ~pwdata[15:0];
        pending_nxt = pending_nxt | src_set;

        in_service_nxt = in_service_levels_r;
        if (wr_in_service)
            in_service_nxt = {pwdata[7:1], 1'b0};
        // Level zero never owns an in-service bit
        if (src_read && (request_level_reg_r != 3'd0))
            in_service_nxt[request_level_reg_r] = 1'b1;
    end

    // ------------------------------------------------------------
    // Fast flag and request lines
    // ------------------------------------------------------------
    always @*
    begin
        fast_mask_nxt = fast_mask_r;
        if (wr_fast)
            fast_mask_nxt = pwdata[`FAST_MASK_BIT];
        // Set wins over a simultaneous one-to-clear
        fast_pend_nxt = fast_pending_flag_r;
        if (fast_fall)
            fast_pend_nxt = 1'b1;
        else if (wr_fast && pwdata[`FAST_PEND_BIT])
            fast_pend_nxt = 1'b0;
    end

    // Held low until the source-number read takes it
    always @*
    begin
        if (src_read)
            normal_nxt = 1'b1;
        else
            normal_nxt = ~any_eligible;
    end

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pending_flag_regs_r  <= 16'h0000;
            level_r              <= `RST_LEVELS;
            in_service_levels_r  <= `RST_IN_SERVICE;
            request_level_reg_r  <= 3'd0;
            source_number_reg_r  <= 4'd0;
            fast_pending_flag_r  <= 1'b0;
            fast_mask_r          <= `RST_FAST_MASK;
            sense_r              <= `RST_SENSE;
            normal_exc_request_n <= 1'b1;
            fast_exc_request_n   <= 1'b1;
        end
        else
        begin
            pending_flag_regs_r <= pending_nxt;
            in_service_levels_r <= in_service_nxt;
            if (wr_level_lo)
                level_r[23:0] <= unpack_levels(pwdata);
            if (wr_level_hi)
                level_r[47:24] <= unpack_levels(pwdata);
            if (wr_sense)
                sense_r <= pwdata[7:0];
            fast_mask_r         <= fast_mask_nxt;
            fast_pending_flag_r <= fast_pend_nxt;
            // Level and number stay frozen while software reads the source number
            if (any_eligible && !src_addr_busy)
            begin
                request_level_reg_r <= best_lvl;
                source_number_reg_r <= best_src;
            end
            normal_exc_request_n <= normal_nxt;
            fast_exc_request_n   <= ~(fast_pend_nxt
                                      & ~fast_mask_nxt);
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always @*
    begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        case (paddr)
            `OFS_PENDING:    rd_mux = {16'h0000, pending_flag_regs_r};
            `OFS_LEVEL_LO:   rd_mux = pack_levels(level_r[23:0]);
            `OFS_LEVEL_HI:   rd_mux = pack_levels(level_r[47:24]);
            `OFS_IN_SERVICE: rd_mux = {24'h00_0000, in_service_levels_r};
            `OFS_REQ_LEVEL:  rd_mux = {29'h0000_0000, request_level_reg_r};
            `OFS_SRC_NUMBER: rd_mux = {28'h000_0000, source_number_reg_r};
            `OFS_FAST_CTRL:  rd_mux = {30'h0000_0000, fast_mask_r,
                                       fast_pending_flag_r};
            `OFS_SENSE_CTRL: rd_mux = {24'h00_0000, sense_r};
            default:         rd_hit = 1'b0;
        endcase
    end

    // Captured in the setup phase, presented through the access phase
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (setup_ph)
        begin
            prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= ~rd_hit;
        end
        else if (!psel)
        begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ---- nested_level_interrupt_control_tb.sv ----
// Self-checking testbench for the nested interrupt control
`timescale 1ns/1ps
`default_nettype none
module nested_level_interrupt_control_tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [7:0]  pins_n = 8'hff;
    logic        fpin_n = 1'b1;
    logic [7:0]  int_req = 8'h00;
    logic        i_bit = 1'b0;
    logic [31:0] rd_q;
    wire         pready;
    wire [31:0]  prdata;
    wire         pslverr;
    wire         irq_n;
    wire         fiq_n;
    wire [7:0]   irq_cnt;
    wire [7:0]   fiq_cnt;
    int          bad_count = 0;
    int          n_compared = 0;
    always #50 pclk = ~pclk;
    nested_level_interrupt_control uut
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .ext_request_pins_n(pins_n),
        .ext_fast_request_pin_n(fpin_n), .int_requests(int_req),
        .normal_exc_request_n(irq_n), .fast_exc_request_n(fiq_n)
    );
    core_model cm
    (
        .pclk(pclk), .presetn(presetn), .normal_exc_request_n(irq_n),
        .fast_exc_request_n(fiq_n), .irq_off(i_bit),
        .irq_taken(irq_cnt), .fiq_taken(fiq_cnt)
    );
    // --------------------------------------------------------------
    // Bus cycles and comparison
    // --------------------------------------------------------------
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
        n_compared++;
        if (seen !== ex)
        begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", nm, ex, seen);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd_q = prdata;
        chk("error flag", {31'h0, pslverr}, {31'h0, a > 8'h1c});
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] ex);
        apb(1'b0, a, 32'h0);
        chk($sformatf("register %h", a), rd_q, ex);
    endtask
    task ins(input logic [31:0] v);
        i_bit <= 1'b1;
        apb(1'b1, 8'h0c, v);
        i_bit <= 1'b0;
    endtask
    task wline(input logic f, input logic ex);
        for (int k = 0; k < 12 && (f ? fiq_n : irq_n) !== ex; k++)
            @(posedge pclk);
        chk(f ? "fast line" : "normal line", {31'h0, f ? fiq_n : irq_n},
            {31'h0, ex});
    endtask
    task quiet(input logic f);
        repeat (8) @(posedge pclk);
        wline(f, 1'b1);
    endtask
    task pulse_int(input logic [7:0] m);
        int_req <= m;
        @(posedge pclk);
        int_req <= 8'h00;
    endtask
    task pulse_fast;
        fpin_n <= 1'b0;
        repeat (3) @(posedge pclk);
        fpin_n <= 1'b1;
    endtask
    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    task t_reset;
        for (int a = 0; a < 36; a += 4)
            rd(a[7:0], 32'h0);
        apb(1'b1, 8'h40, 32'h1);
    endtask
    task t_nested;
        apb(1'b1, 8'h08, 32'h0003_3072);
        pulse_int(8'h04);
        quiet(1'b0);
        pulse_int(8'h01);
        wline(1'b0, 1'b0);
        rd(8'h10, 32'h2);
        rd(8'h14, 32'h8);
        rd(8'h0c, 32'h4);
        pulse_int(8'h01);
        quiet(1'b0);
        pulse_int(8'h02);
        wline(1'b0, 1'b0);
        rd(8'h10, 32'h7);
        rd(8'h14, 32'h9);
        rd(8'h0c, 32'h84);
    endtask
    task t_fast;
        pulse_fast;
        wline(1'b1, 1'b0);
        rd(8'h18, 32'h1);
        apb(1'b1, 8'h18, 32'h1);
        rd(8'h18, 32'h0);
        apb(1'b1, 8'h18, 32'h2);
        pulse_fast;
        quiet(1'b1);
        apb(1'b1, 8'h18, 32'h0);
        wline(1'b1, 1'b0);
        apb(1'b1, 8'h18, 32'h1);
        wline(1'b1, 1'b1);
    endtask
    task t_retire;
        apb(1'b1, 8'h00, 32'h200);
        rd(8'h00, 32'h500);
        ins(32'h4);
        quiet(1'b0);
        apb(1'b1, 8'h00, 32'h500);
        rd(8'h00, 32'h0);
        ins(32'h0);
        pulse_int(8'h18);
        wline(1'b0, 1'b0);
        rd(8'h14, 32'hb);
        rd(8'h10, 32'h3);
        apb(1'b1, 8'h00, 32'h1800);
        ins(32'h0);
    endtask
    task t_pins;
        apb(1'b1, 8'h1c, 32'h2);
        apb(1'b1, 8'h04, 32'h11);
        pins_n <= 8'hfe;
        repeat (3) @(posedge pclk);
        pins_n <= 8'hff;
        wline(1'b0, 1'b0);
        rd(8'h14, 32'h0);
        apb(1'b1, 8'h00, 32'h1);
        rd(8'h00, 32'h0);
        ins(32'h0);
        pins_n <= 8'hfd;
        wline(1'b0, 1'b0);
        rd(8'h14, 32'h1);
        apb(1'b1, 8'h00, 32'h2);
        rd(8'h00, 32'h2);
        pins_n <= 8'hff;
        repeat (3) @(posedge pclk);
        apb(1'b1, 8'h00, 32'h2);
        rd(8'h00, 32'h0);
        ins(32'h0);
    endtask
    task print_verdict;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (3000) @(posedge pclk);
        bad_count++;
        print_verdict;
    end
    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset;
        t_nested;
        t_fast;
        t_retire;
        t_pins;
        chk("normal entries", {24'h0, irq_cnt}, 32'h5);
        chk("fast entries", {24'h0, fiq_cnt}, 32'h2);
        print_verdict;
    end
endmodule
`default_nettype wire
